// File: rtl/serial_adc_control_port_defines.vh
// constants for the serial converter control port
`ifndef SERIAL_ADC_CONTROL_PORT_DEFINES_VH
`define SERIAL_ADC_CONTROL_PORT_DEFINES_VH

// system clock period in ps (250 MHz)
`define CLK_PERIOD_PS        32'd4000
// least sampling window in ns as printed (1.5 us)
`define SAMPLE_WINDOW_NS     32'd1500
// least sampling window in system cycles, rounded up
`define SAMPLE_WINDOW_CYC    ((`SAMPLE_WINDOW_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// conversion time in ns (7.5 us) and in cycles
`define CONV_TIME_NS         32'd7500
`define CONV_TIME_CYC        ((`CONV_TIME_NS * 32'd1000) / `CLK_PERIOD_PS)
// result width and stream length (done bit plus result)
`define RESULT_BITS          10
`define STREAM_BITS          11
// shutdown level encoding: {is_high, is_mid}
`define LEVEL_LOW            2'b00
`define LEVEL_MID            2'b01
`define LEVEL_HIGH           2'b10
// reset values
`define CONV_COUNT_RST       16'h0000
`define RESULT_RST           10'h000
// result bits still to shift after the done flag, and the counter's rest value
`define BIT_CNT_START        4'd10
`define BIT_CNT_RST          4'd0
// sampling window counter rest value and saturation point
`define WINDOW_CNT_RST       16'h0000
`define WINDOW_CNT_MAX       16'hffff
// default conversion length in system cycles (7.5 us)
`define CONV_CYCLES_DFLT     16'd1875

`endif

// File: rtl/conv_timer.v
// down counter that times one conversion on the internal clock
`include "serial_adc_control_port_defines.vh"
`default_nettype none

module conv_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // control
  input  wire        start,
  input  wire        abort,
  input  wire [15:0] length,
  // status
  output reg         busy_reg,
  output reg         done_reg
);

  reg [15:0] count_reg;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= `CONV_COUNT_RST;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (abort) begin
        busy_reg <= 1'b0;
      end else if (start) begin
        count_reg <= length;
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg <= 16'h0001) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/serial_adc_control_port.v
// control and serial read-out of a 10-bit successive-approximation converter
// What this block does
// - a falling chip select ends the sampling window and starts a conversion.
// - the data output is released while chip select is high and driven only while it is low.
// - from the done flag until the next start, the data output changes only after a falling serial clock edge.
// - a low shutdown level powers the block down and blocks conversions.
// - a high or floating shutdown level leaves the block operational.
// - a high level enables the internal scale voltage, floating disables it.
// - when the conversion ends the data output goes high as a done flag.
// - the stream is the done bit then ten result bits, most significant first.
`include "serial_adc_control_port_defines.vh"
`default_nettype none

module serial_adc_control_port #(
  parameter [15:0] CONV_CYCLES = `CONV_CYCLES_DFLT
) (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    sys_rst,
  // host serial pins
  input  wire                    chip_select_n,
  input  wire                    serial_clock,
  output reg                     serial_data_out,
  output reg                     serial_data_oe_n,
  // shutdown level, decoded by the pad into high and mid
  input  wire                    shutdown_level_high,
  input  wire                    shutdown_level_mid,
  // sampled analog value from the converter core
  input  wire [`RESULT_BITS-1:0] analog_input,
  // status to the analog side
  output reg                     power_down,
  output reg                     scale_voltage_enable,
  output reg                     track_hold,
  output reg                     conversion_busy,
  output reg                     sample_window_short
);

  // one-hot states of the read-out sequence
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_CONV  = 4'b0010;
  localparam [3:0] ST_SHIFT = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // two-stage synchronisers on every pin
  reg [1:0]              cs_sync_reg;
  reg [1:0]              sclk_sync_reg;
  reg [1:0]              lvl_hi_sync_reg;
  reg [1:0]              lvl_mid_sync_reg;
  // last settled level of the two strobes, for edge finding
  reg                    cs_last_reg;
  reg                    sclk_last_reg;

  reg [3:0]              state_reg;
  reg [3:0]              state_next;
  reg [`RESULT_BITS-1:0] shift_reg;
  reg [3:0]              bit_cnt_reg;
  reg [15:0]             window_cnt_reg;

  wire                   cs_n;
  wire                   cs_fall;
  wire                   sclk_fall;
  wire [1:0]             level_code;
  wire                   powered;
  wire                   start;
  wire                   abort;
  wire                   capture;
  wire                   shift_step;
  wire                   tail_step;
  wire                   conv_done;
  wire                   conv_busy;

  // a level fell between the last settled sample and this one
  function falling;
    input last_level;
    input now_level;
    begin
      falling = last_level & ~now_level;
    end
  endfunction

  // any shutdown level but low keeps the converter awake
  function level_awake;
    input [1:0] code;
    begin
      level_awake = (code != `LEVEL_LOW);
    end
  endfunction

  assign cs_n       = cs_sync_reg[1];
  assign cs_fall    = falling(cs_last_reg, cs_n);
  assign sclk_fall  = falling(sclk_last_reg, sclk_sync_reg[1]);
  assign level_code = {lvl_hi_sync_reg[1], lvl_mid_sync_reg[1]};
  assign powered    = level_awake(level_code);
  // a start is taken only from idle, so a second fall during a conversion is ignored
  assign start      = cs_fall & powered & (state_reg == ST_IDLE);
  // raising chip select or shutting down throws the running conversion away
  assign abort      = cs_n | ~powered;
  assign capture    = (state_reg == ST_CONV) & conv_done & ~abort;
  assign shift_step = (state_reg == ST_SHIFT) & sclk_fall;
  assign tail_step  = (state_reg == ST_DONE) & sclk_fall;

  conv_timer u_timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .start    (start),
    .abort    (abort),
    .length   (CONV_CYCLES),
    .busy_reg (conv_busy),
    .done_reg (conv_done)
  );

  // two flip-flops per pin before anything reads it, then one more for edge finding
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync_reg      <= 2'b11;
      sclk_sync_reg    <= 2'b00;
      lvl_hi_sync_reg  <= 2'b00;
      lvl_mid_sync_reg <= 2'b00;
      cs_last_reg      <= 1'b1;
      sclk_last_reg    <= 1'b0;
    end else begin
      cs_sync_reg      <= {cs_sync_reg[0], chip_select_n};
      sclk_sync_reg    <= {sclk_sync_reg[0], serial_clock};
      lvl_hi_sync_reg  <= {lvl_hi_sync_reg[0], shutdown_level_high};
      lvl_mid_sync_reg <= {lvl_mid_sync_reg[0], shutdown_level_mid};
      cs_last_reg      <= cs_n;
      sclk_last_reg    <= sclk_sync_reg[1];
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort) begin
          state_next = ST_IDLE;
        end else if (conv_done) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_n) begin
          state_next = ST_IDLE;
        end else if (sclk_fall && bit_cnt_reg == `BIT_CNT_RST) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cs_n) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // status to the analog side, registered so no decode glitch reaches the core
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      power_down           <= 1'b1;
      scale_voltage_enable <= 1'b0;
      conversion_busy      <= 1'b0;
      track_hold           <= 1'b0;
    end else begin
      power_down           <= ~powered;
      scale_voltage_enable <= (level_code == `LEVEL_HIGH);
      conversion_busy      <= conv_busy;
      track_hold           <= (state_next == ST_CONV);
    end
  end

  // the pin follows chip select one synchroniser delay plus one register late, in both directions
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serial_data_oe_n <= 1'b1;
    end else begin
      serial_data_oe_n <= cs_n;
    end
  end

  // watch the host's sampling window; a short one only flags, it is not refused
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      window_cnt_reg      <= `WINDOW_CNT_RST;
      sample_window_short <= 1'b0;
    end else begin
      if (cs_n) begin
        if (window_cnt_reg != `WINDOW_CNT_MAX) begin
          window_cnt_reg <= window_cnt_reg + 16'h0001;
        end
      end else begin
        window_cnt_reg <= `WINDOW_CNT_RST;
      end
      if (cs_fall) begin
        sample_window_short <= (window_cnt_reg < `SAMPLE_WINDOW_CYC);
      end
    end
  end

  // result word and the number of result bits still to send
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg   <= `RESULT_RST;
      bit_cnt_reg <= `BIT_CNT_RST;
    end else if (capture) begin
      // caught when the internal timing ends, so the core has settled its code
      shift_reg   <= analog_input;
      bit_cnt_reg <= `BIT_CNT_START;
    end else if (shift_step) begin
      shift_reg <= {shift_reg[`RESULT_BITS-2:0], 1'b0};
      // the extra fall after the last bit must not wrap the count
      if (bit_cnt_reg != `BIT_CNT_RST) begin
        bit_cnt_reg <= bit_cnt_reg - 4'd1;
      end
    end
  end

  // data pin: low while converting, done flag, then the result from the top bit down
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serial_data_out <= 1'b0;
    end else if (start) begin
      serial_data_out <= 1'b0;
    end else if (capture) begin
      serial_data_out <= 1'b1;
    end else if (shift_step) begin
      serial_data_out <= shift_reg[`RESULT_BITS-1];
    end else if (tail_step) begin
      serial_data_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: testbench/port_chk_assertions.sv
// assertions on the converter control port pins
`default_nettype none
module port_chk #(parameter [15:0] CONV_CYCLES = 16'd1875) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  input wire logic power_down,
  input wire logic scale_voltage_enable,
  input wire logic track_hold,
  input wire logic conversion_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a chip-select abort raises chip select first, so a fall with it still low is a full conversion or a shutdown abort
  sequence conv_end; $fell(conversion_busy) && !chip_select_n; endsequence
  always @(posedge clk_sys or posedge sys_rst) n <= sys_rst ? 16'h0000 : (conversion_busy ? n + 16'h0001 : 16'h0000);
  cs_release_a: assert property (chip_select_n [*5] |-> serial_data_oe_n) else $error("pin kept");
  cs_drive_a: assert property ((!chip_select_n && !power_down) [*5] |-> !serial_data_oe_n) else $error("pin idle");
  conv_start_a: assert property ($fell(chip_select_n) && !power_down && !conversion_busy |-> ##[2:5] track_hold)
    else $error("no start");
  data_hold_a: assert property (serial_clock [*2] |-> $stable(serial_data_out)) else $error("data moved");
  pd_idle_a: assert property (power_down [*2] |-> !conversion_busy && !track_hold) else $error("busy");
  scale_off_a: assert property (scale_voltage_enable |-> !power_down) else $error("scale on");
  done_flag_a: assert property (conv_end |-> ##[1:3] serial_data_out) else $error("no done");
  conv_len_a: assert property (conv_end |-> n >= CONV_CYCLES - 16'd1 && n <= CONV_CYCLES + 16'd1) else $error("length");
endmodule
bind serial_adc_control_port port_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
  .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n), .power_down(power_down),
  .scale_voltage_enable(scale_voltage_enable), .track_hold(track_hold), .conversion_busy(conversion_busy));
`default_nettype wire

// File: testbench/host_model.sv
// host model: three-wire read-out master
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  output var logic chip_select_n,
  output var logic serial_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  logic [10:0] word;
  event word_ev;
  // a released line floats: show the inverse of the last driven bit
  wire line = serial_data_oe_n ? ~last : serial_data_out;
  always @(posedge clk_sys) if (!serial_data_oe_n) last <= serial_data_out;
  initial {chip_select_n, serial_clock} = 2'b10;
  task automatic wt(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // hold > 0 only drops chip select; each clock phase is 60 cycles, 480 ns a period
  task automatic frame(input int gap, input int hold);
    int k;
    k = 0;
    wt(gap);
    chip_select_n = 1'b0;
    wt(hold > 0 ? hold : 60);
    while (hold == 0 && line !== 1'b1 && k < 2000) begin
      wt(1);
      k++;
    end
    for (int i = 10; i >= 0 && hold == 0; i--) begin
      serial_clock = 1'b0;
      wt(60);
      serial_clock = 1'b1;
      word[i] = line;
      wt(60);
    end
    serial_clock = 1'b0;
    if (hold == 0) wt(60);
    chip_select_n = 1'b1;
    if (hold == 0) -> word_ev;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the converter control port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic shutdown_level_high = 1'b1;
  logic shutdown_level_mid = 1'b0;
  logic [9:0] analog_input = 10'h000;
  wire chip_select_n, serial_clock, serial_data_out, serial_data_oe_n;
  wire power_down, scale_voltage_enable, track_hold, conversion_busy, sample_window_short;
  int error_cnt = 0;
  int n_tests = 0;
  logic [10:0] exp_q[$];
  logic [31:0] r;
  serial_adc_control_port #(.CONV_CYCLES(16'd50)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .shutdown_level_high(shutdown_level_high), .shutdown_level_mid(shutdown_level_mid),
    .analog_input(analog_input), .power_down(power_down), .scale_voltage_enable(scale_voltage_enable),
    .track_hold(track_hold), .conversion_busy(conversion_busy), .sample_window_short(sample_window_short));
  host_model h (.clk_sys(clk_sys), .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [9:0] code_val, input int gap);
    analog_input = code_val;
    exp_q.push_back({1'b1, code_val});
    h.frame(gap, 0);
  endtask
  always @(h.word_ev) chk("word", h.word, exp_q.pop_front());
  initial begin
    void'($urandom(32'hd9474649));
    h.wt(4);
    sys_rst = 1'b0;
    for (int m = 0; m < 3; m++) begin
      {shutdown_level_high, shutdown_level_mid} = m[1:0];
      h.wt(8);
      chk("power_down", power_down, m == 0);
      chk("scale", scale_voltage_enable, m == 2);
      r = $urandom;
      if (m == 0) begin
        fork h.frame(400, 100);
        begin h.wt(450); chk("busy", track_hold, 1'b0); end join
      end else begin
        rd(10'h3ff, 400);
        rd(r[9:0], 400);
      end
    end
    h.frame(400, 20);
    h.wt(8);
    chk("abort", {conversion_busy, serial_data_oe_n}, 2'b01);
    rd(10'h000, 400);
    rd(r[9:0] ^ 10'h155, 100);
    chk("short", sample_window_short, 1'b1);
    rd(10'h2aa, 400);
    chk("long", sample_window_short, 1'b0);
    h.wt(1);
    complete_run();
  end
  initial begin
    // the tests need about 14k cycles; this allows more than twice that
    #150000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
